// File: verilog/gtt_pkg.sv
/*
 * Shared constants and types for the gear tooth threshold tracker.
 * Assumes a single 25 MHz clock domain and an unsigned sampled gradient.
 */
package gtt_pkg;

    // Sample widths
    localparam int RAW_W = 12;                  // Raw gradient sample width
    localparam int NORM_W = 16;                 // Normalised signal width
    localparam int SHIFT_W = 3;                 // Gain shift field width

    // Switch point fractions, in percent of peak-to-peak span
    localparam int RELEASE_PCT = 30;            // Falling threshold
    localparam int OPERATE_PCT = 70;            // Rising threshold
    localparam int PCT_FULL = 100;              // Divisor for percentages

    // Gain normaliser settings
    localparam logic [NORM_W-1:0] TARGET_SPAN = 16'hC000; // Wanted normalised amplitude
    localparam logic [SHIFT_W-1:0] MAX_SHIFT = 3'h4;      // Largest gain step (x16)
    localparam logic [RAW_W-1:0] MIN_RAW_SPAN = 12'h020;  // Least span that counts as an edge

    // Edges needed before running mode
    localparam logic [1:0] CAL_EDGES = 2'h2;

    // Output levels; OFF is the high level
    localparam logic OUT_OFF = 1'b1;            // Over the tooth / power-on level
    localparam logic OUT_ON = 1'b0;             // Driven low

    // Sequencer states, gray along power-up path
    typedef enum logic [1:0] {
        GTT_LOCKOUT = 2'b00,                    // Supply low, output held OFF
        GTT_CALIB = 2'b01,                      // Measuring raw span
        GTT_RUN = 2'b11                         // Normalised tracking
    } gtt_state_t;

    // Switching threshold pair
    typedef struct packed {
        logic [NORM_W-1:0] low;                 // Release point
        logic [NORM_W-1:0] high;                // Operate point
    } gtt_thresh_t;

endpackage

// File: verilog/gtt_tracker.sv
/*
 * Gear tooth threshold tracker: gain normaliser, peak/valley trackers,
 * adaptive hysteretic comparator and lockout-gated digital output.
 * Assumes SIG_IN and SUPPLY_OK are synchronous to CLK, one sample per clock.
 */
`timescale 1ns/1ps

module gtt_tracker
    import gtt_pkg::*;
(
    input wire logic CLK,                        // 25 MHz sample clock
    input wire logic RSTN,                       // Async reset, active low
    input wire logic [RAW_W-1:0] SIG_IN,         // Amplified gradient sample
    input wire logic SUPPLY_OK,                  // High above supply_lockout_level
    output logic TOOTH_OUT,                      // Digital tooth output, high = OFF
    output logic CAL_DONE,                       // High in running mode
    output logic [SHIFT_W-1:0] GAIN_SHIFT,       // Gain chosen by gain_normalizer
    output gtt_thresh_t THRESH                   // Thresholds now in use
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Point at pct percent of the span above base
    function automatic logic [NORM_W-1:0] frac_point(
        input logic [NORM_W-1:0] base,
        input logic [NORM_W-1:0] span,
        input int pct
    );
        logic [31:0] part;
        part = (32'(span) * 32'(pct)) / 32'(PCT_FULL);
        frac_point = base + part[NORM_W-1:0];
    endfunction

    // Largest shift that keeps the amplified span within target
    function automatic logic [SHIFT_W-1:0] pick_shift(input logic [RAW_W-1:0] span);
        logic [SHIFT_W-1:0] s;
        logic [NORM_W-1:0] wide;
        s = '0;
        for (int i = 0; i <= int'(MAX_SHIFT); i++) begin
            wide = NORM_W'(span) << i;
            if (wide <= TARGET_SPAN) begin
                s = SHIFT_W'(i);
            end
        end
        pick_shift = s;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    gtt_state_t state;                           // Sequencer state
    logic comp;                                  // Comparator state, 1 = high side
    logic comp_known;                            // Set once first edge is seen
    logic [1:0] edge_cnt;                        // Edges seen in calibration
    logic [RAW_W-1:0] raw_max;                   // Raw maximum during calibration
    logic [RAW_W-1:0] raw_min;                   // Raw minimum during calibration
    logic [NORM_W-1:0] peak;                     // Last completed peak
    logic [NORM_W-1:0] valley;                   // Last completed valley
    logic [NORM_W-1:0] run_max;                  // Peak of current high phase
    logic [NORM_W-1:0] run_min;                  // Valley of current low phase
    logic [NORM_W-1:0] norm;                     // Normalised sample
    logic [RAW_W-1:0] raw_span;                  // Calibration span so far
    logic [NORM_W-1:0] cal_lo;                   // Calibration release point
    logic [NORM_W-1:0] cal_hi;                   // Calibration operate point
    logic [NORM_W-1:0] run_span;                 // Span of latched extremes
    gtt_thresh_t run_thr;                        // Running thresholds
    logic cal_fall;                              // Falling edge in calibration
    logic cal_rise;                              // Rising edge in calibration
    logic run_fall;                              // Falling edge while running
    logic run_rise;                              // Rising edge while running
    logic cal_finish;                            // Second edge reached
    logic next_out;                              // Next output level

    ////////////////////////////////////////////////////////////////////////
    // Signal conditioning

    // Gain applies as a left shift; offset stays but thresholds absorb it
    assign norm = NORM_W'(SIG_IN) << GAIN_SHIFT;
    assign raw_span = raw_max - raw_min;

    // Calibration points on the raw scale, same fractions as running
    assign cal_lo = frac_point(NORM_W'(raw_min), NORM_W'(raw_span), RELEASE_PCT);
    assign cal_hi = frac_point(NORM_W'(raw_min), NORM_W'(raw_span), OPERATE_PCT);

    // Thresholds measured from valley, so a common shift cancels
    assign run_span = (peak > valley) ? (peak - valley) : '0;
    assign run_thr.low = frac_point(valley, run_span, RELEASE_PCT);
    assign run_thr.high = frac_point(valley, run_span, OPERATE_PCT);

    ////////////////////////////////////////////////////////////////////////
    // Edge detection

    // Calibration edges need a meaningful span first
    always_comb begin
        cal_fall = 1'b0;
        cal_rise = 1'b0;
        if (state == GTT_CALIB && raw_span >= MIN_RAW_SPAN) begin
            // First edge in either direction is accepted
            if (NORM_W'(SIG_IN) <= cal_lo && (!comp_known || comp)) begin
                cal_fall = 1'b1;
            end else if (NORM_W'(SIG_IN) >= cal_hi && (!comp_known || !comp)) begin
                cal_rise = 1'b1;
            end
        end
    end

    // Only the crossing opposite the present state switches
    assign run_fall = (state == GTT_RUN) && comp && (norm < run_thr.low);
    assign run_rise = (state == GTT_RUN) && !comp && (norm > run_thr.high);
    assign cal_finish = (cal_fall || cal_rise) && (edge_cnt == CAL_EDGES - 2'h1);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    // Any supply dip restarts from lockout, so each power-up recalibrates
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state <= GTT_LOCKOUT;
        end else if (!SUPPLY_OK) begin
            state <= GTT_LOCKOUT;
        end else begin
            unique case (state)
                GTT_LOCKOUT: begin
                    state <= GTT_CALIB;
                end
                GTT_CALIB: begin
                    if (cal_finish) begin
                        state <= GTT_RUN;
                    end
                end
                GTT_RUN: begin
                    state <= GTT_RUN;
                end
                default: begin
                    state <= GTT_LOCKOUT;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Calibration span and edge count

    // Raw extremes restart from the live sample on entry
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            raw_max <= '0;
            raw_min <= '0;
            edge_cnt <= '0;
        end else if (state != GTT_CALIB) begin
            raw_max <= SIG_IN;
            raw_min <= SIG_IN;
            edge_cnt <= '0;
        end else begin
            if (SIG_IN > raw_max) begin
                raw_max <= SIG_IN;
            end
            if (SIG_IN < raw_min) begin
                raw_min <= SIG_IN;
            end
            if (cal_fall || cal_rise) begin
                edge_cnt <= edge_cnt + 2'h1;
            end
        end
    end

    // Gain is fixed once, at the end of calibration
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            GAIN_SHIFT <= '0;
        end else if (state == GTT_LOCKOUT) begin
            GAIN_SHIFT <= '0;
        end else if (state == GTT_CALIB && cal_finish) begin
            GAIN_SHIFT <= pick_shift(raw_span);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Comparator state

    // Powers up on the high side, so a rising first edge is silent
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            comp <= OUT_OFF;
            comp_known <= 1'b0;
        end else if (state == GTT_LOCKOUT) begin
            comp <= OUT_OFF;
            comp_known <= 1'b0;
        end else if (cal_fall || run_fall) begin
            comp <= 1'b0;
            comp_known <= 1'b1;
        end else if (cal_rise || run_rise) begin
            comp <= 1'b1;
            comp_known <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Peak and valley trackers

    // Extremes of the phase that just ended become the new reference,
    // so each edge uses data from the two edges before it
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            peak <= '0;
            valley <= '0;
            run_max <= '0;
            run_min <= '0;
        end else if (state == GTT_CALIB) begin
            // Seed with the calibration extremes at the chosen gain
            peak <= NORM_W'(raw_max) << pick_shift(raw_span);
            valley <= NORM_W'(raw_min) << pick_shift(raw_span);
            run_max <= '0;
            run_min <= '1;
        end else if (state == GTT_RUN) begin
            if (run_fall) begin
                peak <= (norm > run_max) ? norm : run_max;
                run_min <= norm;
            end else if (run_rise) begin
                valley <= (norm < run_min) ? norm : run_min;
                run_max <= norm;
            end else begin
                // Continuous tracking within the current phase
                if (norm > run_max) begin
                    run_max <= norm;
                end
                if (norm < run_min) begin
                    run_min <= norm;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Lockout overrides the comparator; polarity follows the gradient sign,
    // so reverse rotation inverts the output with no extra logic
    always_comb begin
        if (!SUPPLY_OK || state == GTT_LOCKOUT) begin
            next_out = OUT_OFF;
        end else if (cal_fall || run_fall) begin
            next_out = OUT_ON;
        end else if (cal_rise || run_rise) begin
            next_out = OUT_OFF;
        end else begin
            next_out = comp;
        end
    end

    // Registered output and status
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            TOOTH_OUT <= OUT_OFF;
            CAL_DONE <= 1'b0;
            THRESH <= '0;
        end else begin
            TOOTH_OUT <= next_out;
            CAL_DONE <= SUPPLY_OK && (state == GTT_RUN || cal_finish);
            THRESH <= run_thr;
        end
    end

endmodule

// File: test/gtt_tracker_sva.sv
/*
 * Port-level assertions for the gear tooth threshold tracker.
 * Assumes one CLK domain and RSTN as the asynchronous active-low reset.
 */
`timescale 1ns/1ps
module gtt_tracker_sva
    import gtt_pkg::*;
(
    input wire logic CLK,                       // Sample clock
    input wire logic RSTN,                      // Reset, active low
    input wire logic [RAW_W-1:0] SIG_IN,        // Raw gradient sample
    input wire logic SUPPLY_OK,                 // Supply above lockout
    input wire logic TOOTH_OUT,                 // Output, high = OFF
    input wire logic CAL_DONE,                  // Running mode
    input wire logic [SHIFT_W-1:0] GAIN_SHIFT,  // Chosen gain
    input wire gtt_thresh_t THRESH              // Thresholds in use
);
    default clocking cb_main @(posedge CLK); endclocking
    default disable iff (!RSTN);

    ////////////////////////////////////////////////////////////////////////
    // Normalised sample, as the comparator sees it
    logic [NORM_W-1:0] norm;
    assign norm = NORM_W'(SIG_IN) << GAIN_SHIFT;

    // Settled running: thresholds no longer carry calibration leftovers
    sequence s_steady;
        CAL_DONE && $past(CAL_DONE, 3) && $past(SUPPLY_OK);
    endsequence

    ////////////////////////////////////////////////////////////////////////
    a_lockout_off: assert property (
        !SUPPLY_OK |=> (TOOTH_OUT == OUT_OFF) && !CAL_DONE) else $error("output not OFF in lockout");
    a_gain_range: assert property (
        GAIN_SHIFT <= MAX_SHIFT) else $error("gain beyond largest step");
    a_gain_fixed: assert property (
        CAL_DONE && $past(CAL_DONE) |-> $stable(GAIN_SHIFT)) else $error("gain moved while running");
    a_second_edge: assert property (
        $rose(CAL_DONE) |-> $changed(TOOTH_OUT)) else $error("second edge gave no transition");
    a_fall_supply: assert property (
        $fell(TOOTH_OUT) |-> $past(SUPPLY_OK)) else $error("falling edge without supply");
    a_thresh_order: assert property (
        s_steady |-> THRESH.low <= THRESH.high) else $error("release above operate point");
    a_rise_cross: assert property (
        $rose(TOOTH_OUT) ##0 s_steady |-> $past(norm) > $past(THRESH.high)) else $error("rise below operate point");
    a_fall_cross: assert property (
        $fell(TOOTH_OUT) ##0 s_steady |-> $past(norm) < $past(THRESH.low)) else $error("fall above release point");
endmodule

bind gtt_tracker gtt_tracker_sva u_sva (.CLK(CLK), .RSTN(RSTN), .SIG_IN(SIG_IN), .SUPPLY_OK(SUPPLY_OK),
    .TOOTH_OUT(TOOTH_OUT), .CAL_DONE(CAL_DONE), .GAIN_SHIFT(GAIN_SHIFT), .THRESH(THRESH));

// File: test/gtt_pulse_reader.sv
/*
 * Controller side: samples the tooth pulse and counts its edges.
 * Assumes the pulse is sampled on the same clock as the sensor logic.
 */
`timescale 1ns/1ps
module gtt_pulse_reader (
    input wire logic clk,                       // Controller sample clock
    input wire logic rst_n,                     // Reset, active low
    input wire logic tooth_out,                 // Pulse from the sensor
    output logic [15:0] rise_count,             // Low-to-high edges seen
    output logic [15:0] fall_count              // High-to-low edges seen
);
    logic last; // Previous sample; starts at the OFF level

    ////////////////////////////////////////////////////////////////////////
    // Edge counter; a real input would also debounce, not needed here
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last <= 1'b1;
            rise_count <= 16'h0000;
            fall_count <= 16'h0000;
        end else begin
            last <= tooth_out;
            if (tooth_out && !last) begin
                rise_count <= rise_count + 16'h0001;
            end
            if (!tooth_out && last) begin
                fall_count <= fall_count + 16'h0001;
            end
        end
    end
endmodule

// File: test/gtt_tracker_tb.sv
/*
 * Self-checking bench for the tracker: power-on, calibration, running
 * thresholds, baseline shift and supply lockout.
 * Assumes the checker is bound in and the pulse reader models the controller.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin num_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module gtt_tracker_tb;
    import gtt_pkg::*;
    logic CLK = 1'b0;                           // 25 MHz clock
    logic RSTN = 1'b0;                          // Reset, active low
    logic [RAW_W-1:0] SIG_IN = 12'h000;         // Gradient stimulus
    logic SUPPLY_OK = 1'b1;                     // Supply good
    logic TOOTH_OUT, CAL_DONE;                  // Design outputs
    logic [SHIFT_W-1:0] GAIN_SHIFT;
    gtt_thresh_t THRESH;
    logic [15:0] rises, falls;                  // Reader counts
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;

    always #20 CLK = ~CLK;

    gtt_tracker u_dut (.CLK(CLK), .RSTN(RSTN), .SIG_IN(SIG_IN), .SUPPLY_OK(SUPPLY_OK),
        .TOOTH_OUT(TOOTH_OUT), .CAL_DONE(CAL_DONE), .GAIN_SHIFT(GAIN_SHIFT), .THRESH(THRESH));
    gtt_pulse_reader u_reader (.clk(CLK), .rst_n(RSTN), .tooth_out(TOOTH_OUT),
        .rise_count(rises), .fall_count(falls));

    ////////////////////////////////////////////////////////////////////////
    // Expected gain: largest shift keeping the span under the target
    function automatic logic [SHIFT_W-1:0] exp_gain(input int span);
        logic [SHIFT_W-1:0] s;
        s = 3'h0;
        while (s < MAX_SHIFT && (span << (s + 1)) <= int'(TARGET_SPAN)) s++;
        return s;
    endfunction

    // Expected thresholds from valley and peak, floored
    function automatic gtt_thresh_t exp_thr(input int lo, input int hi);
        gtt_thresh_t t;
        t.low = NORM_W'(lo + (hi - lo) * RELEASE_PCT / PCT_FULL);
        t.high = NORM_W'(lo + (hi - lo) * OPERATE_PCT / PCT_FULL);
        return t;
    endfunction

    // One sample, driven just after the edge
    task automatic step(input logic [RAW_W-1:0] v);
        @(posedge CLK);
        #1 SIG_IN = v;
    endtask

    // One tooth: ramp base up by 0x100 and back in steps of 4
    task automatic tooth(input logic [RAW_W-1:0] base, input bit chk);
        for (int i = 0; i <= 64; i++) step(base + 12'(i * 4));
        if (chk) `CHK("tooth level", OUT_OFF, TOOTH_OUT)
        for (int i = 64; i >= 0; i--) step(base + 12'(i * 4));
        if (chk) `CHK("gap level", OUT_ON, TOOTH_OUT)
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_power_on();
        repeat (6) @(posedge CLK);
        `CHK("reset out", OUT_OFF, TOOTH_OUT)
        `CHK("reset cal", 1'b0, CAL_DONE)
        #1 RSTN = 1'b1;
    endtask

    // Rising first edge stays silent, falling second one enters running
    task automatic t_calibrate(input logic [15:0] nfall);
        for (int i = 0; i <= 64; i++) step(12'(i * 4));
        `CHK("first edge silent", OUT_OFF, TOOTH_OUT)
        `CHK("cal pending", 1'b0, CAL_DONE)
        for (int i = 64; i >= 0; i--) step(12'(i * 4));
        `CHK("first fall", OUT_ON, TOOTH_OUT)
        `CHK("cal done", 1'b1, CAL_DONE)
        `CHK("gain", exp_gain(256), GAIN_SHIFT)
        `CHK("reader falls", nfall, falls)
    endtask

    // Thresholds follow the last two edges, shifted baseline included
    task automatic t_running(input logic [RAW_W-1:0] base);
        int b;
        b = int'(base) << exp_gain(256);
        tooth(base, 1'b0);
        repeat (2) tooth(base, 1'b1);
        `CHK("thresholds", exp_thr(b, b + 4096), THRESH)
    endtask

    // Reverse rotation: the tooth now faces while the gradient is low,
    // so the output must read ON over the tooth and OFF over the gap
    task automatic t_reverse();
        for (int i = 64; i >= 0; i--) step(12'(i * 4));
        `CHK("reverse tooth", OUT_ON, TOOTH_OUT)
        for (int i = 0; i <= 64; i++) step(12'(i * 4));
        `CHK("reverse gap", OUT_OFF, TOOTH_OUT)
    endtask

    // Supply drop forces OFF, then a fresh calibration
    task automatic t_lockout();
        logic [15:0] f0;
        logic [15:0] r0;
        f0 = falls;
        r0 = rises;
        @(posedge CLK);
        #1 SUPPLY_OK = 1'b0;
        tooth(12'h000, 1'b0);
        `CHK("lockout out", OUT_OFF, TOOTH_OUT)
        `CHK("lockout falls", f0, falls)
        `CHK("lockout rise", r0 + 16'h0001, rises)
        `CHK("lockout cal", 1'b0, CAL_DONE)
        SUPPLY_OK = 1'b1;
        t_calibrate(f0 + 16'h0001);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Hang guard; the full run needs under 2000 cycles
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            print_verdict();
        end
    end

    initial begin
        t_power_on();
        t_calibrate(16'h0001);
        t_running(12'h000);
        t_reverse();
        t_running(12'h010);
        t_lockout();
        print_verdict();
    end
endmodule
